// ### design/gpm_pkg.sv
// package for the pin port: register offsets, field layout, reset values, mode codes
// assumes a 32-bit register bus with word-aligned byte addresses
package gpm_pkg;
	localparam int unsigned NUM_PINS = 26;
	localparam int unsigned ADDR_W = 7;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [6:0] OFF_PIN_DATA = 7'h00;
	localparam logic [6:0] OFF_PIN_DIRECTION = 7'h04;
	localparam logic [6:0] OFF_PULL_ENABLE = 7'h08;
	localparam logic [6:0] OFF_DRIVE_STRENGTH = 7'h0c;
	localparam logic [6:0] OFF_IRQ_SENSE_SELECT = 7'h10;
	localparam logic [6:0] OFF_IRQ_BOTH_EDGES = 7'h14;
	localparam logic [6:0] OFF_IRQ_POLARITY = 7'h18;
	localparam logic [6:0] OFF_IRQ_MASK = 7'h1c;
	localparam logic [6:0] OFF_IRQ_MASKED_STATUS = 7'h24;
	localparam logic [6:0] OFF_IRQ_CLEAR = 7'h28;
	localparam logic [6:0] OFF_FUNCTION_SELECT_0 = 7'h2c;
	localparam logic [6:0] OFF_FUNCTION_SELECT_1 = 7'h30;
	localparam logic [6:0] OFF_FUNCTION_SELECT_2 = 7'h34;
	localparam logic [6:0] OFF_FUNCTION_SELECT_3 = 7'h38;
	localparam logic [6:0] OFF_DATA_ATOMIC_SET = 7'h3c;
	localparam logic [6:0] OFF_DATA_ATOMIC_CLEAR = 7'h40;
	localparam logic [6:0] OFF_TIMER_INPUT_SELECT = 7'h44;
	// ------------------------------------------------------------
	// reset values and field layout
	// ------------------------------------------------------------
	localparam logic [25:0] RST_PULL_ENABLE = 26'h3ffffff;
	// packed 3-bit fields: pins 9 and 10 start in serial function one
	localparam logic [77:0] RST_FUNC = 78'h48000000;
	localparam int unsigned FUNC_W = 3;
	localparam int unsigned FUNC_STRIDE = 4;
	localparam int unsigned PINS_PER_FSEL = 8;
	localparam int unsigned TSEL_W = 8;
	localparam logic [7:0] TSEL_MAX = 8'h19;
	// ------------------------------------------------------------
	// function codes
	// ------------------------------------------------------------
	localparam logic [2:0] FN_PORT = 3'h0;
	localparam logic [2:0] FN_SERIAL_ONE = 3'h1;
	localparam logic [2:0] FN_SERIAL_ZERO = 3'h4;
	localparam logic [2:0] FN_SERIAL_TWO = 3'h5;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### design/gpm_port.sv
// pin port with function mux and timer capture routing, axi4-lite slave
// assumes pins sampled synchronously to aclk; serial peripherals and timers outside
// ------------------------------------------------------------
// Overview of operation
// - port-mode output pins drive the stored data bit.
// - data register reads return actual pin levels.
// - direction bit one is output; all pins reset to input.
// - pull enable per pin, resets all 26 bits set.
// - drive strength per pin, resets to low drive.
// - sense bit chooses edge (0) or level (1) detection.
// - edge pins choose single edge (0) or both edges (1).
// - polarity chooses falling/low (0) or rising/high (1).
// - mask bit one enables pin interrupt; resets disabled.
// - masked status is read-only, pending AND mask.
// - writing one to clear register clears pending; zero does nothing.
// - first function register holds pins 0-7, reserved bits read zero.
// - second function register pins 8-15; pins 9 and 10 reset to one.
// - third function register pins 16-23, all reset to zero.
// - fourth function register only pins 24 and 25; rest reads zero.
// - atomic set sets data bits of port-mode pins only.
// - atomic clear clears data bits of port-mode pins only.
// - timer select holds four 8-bit pin indices, 0x00 to 0x19.
// - function codes: 000 port, 001 serial one, 100 zero, 101 two.
// - selected pin routes to its timer capture input.
// - all pins high impedance while in reset.
// ------------------------------------------------------------
module gpm_port #(
	parameter int unsigned NPIN = gpm_pkg::NUM_PINS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [6:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [6:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NPIN-1:0] pin_in,
	output logic [NPIN-1:0] pin_out,
	output logic [NPIN-1:0] pin_oe,
	output logic [NPIN-1:0] pin_pull_en,
	output logic [NPIN-1:0] pin_high_drive,
	input wire logic [NPIN-1:0] serial_zero_out,
	input wire logic [NPIN-1:0] serial_zero_oe,
	input wire logic [NPIN-1:0] serial_one_out,
	input wire logic [NPIN-1:0] serial_one_oe,
	input wire logic [NPIN-1:0] serial_two_out,
	input wire logic [NPIN-1:0] serial_two_oe,
	output logic [NPIN-1:0] serial_zero_in,
	output logic [NPIN-1:0] serial_one_in,
	output logic [NPIN-1:0] serial_two_in,
	output logic timer_unit1_capture_a,
	output logic timer_unit1_capture_b,
	output logic timer_unit2_capture_a,
	output logic timer_unit2_capture_b,
	output logic irq
);
	localparam int unsigned FW = gpm_pkg::FUNC_W;

	typedef struct packed {
		logic aw_held;
		logic [6:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [NPIN-1:0] pin_data;
		logic [NPIN-1:0] pin_direction;
		logic [NPIN-1:0] pull_enable;
		logic [NPIN-1:0] drive_strength;
		logic [NPIN-1:0] irq_sense_select;
		logic [NPIN-1:0] irq_both_edges;
		logic [NPIN-1:0] irq_polarity;
		logic [NPIN-1:0] irq_mask;
		logic [NPIN-1:0] pending;
		logic [NPIN-1:0] pin_prev;
		logic [NPIN*FW-1:0] func;
		logic [31:0] timer_sel;
		logic in_reset;
	} gpm_state_t;

	gpm_state_t st_ff;
	gpm_state_t nxt_st;

	logic [NPIN-1:0] is_port;
	logic [NPIN-1:0] is_s0;
	logic [NPIN-1:0] is_s1;
	logic [NPIN-1:0] is_s2;
	logic [NPIN-1:0] cond;
	logic [NPIN-1:0] masked;
	logic [NPIN-1:0] pad_out;
	logic [NPIN-1:0] pad_oe;
	logic [4*FW*8-1:0] func_padded;

	// ------------------------------------------------------------
	// per-pin function decode, pad mux and event detection
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_pin
			logic [FW-1:0] fn;
			logic rise;
			logic fall;
			assign fn = st_ff.func[g*FW +: FW];
			// function decode
			assign is_port[g] = (fn == gpm_pkg::FN_PORT);
			assign is_s0[g] = (fn == gpm_pkg::FN_SERIAL_ZERO);
			assign is_s1[g] = (fn == gpm_pkg::FN_SERIAL_ONE);
			assign is_s2[g] = (fn == gpm_pkg::FN_SERIAL_TWO);
			// serial function owns value and direction
			always_comb
			begin
				if (is_s0[g])
				begin
					pad_out[g] = serial_zero_out[g];
					pad_oe[g] = serial_zero_oe[g];
				end
				else if (is_s1[g])
				begin
					pad_out[g] = serial_one_out[g];
					pad_oe[g] = serial_one_oe[g];
				end
				else if (is_s2[g])
				begin
					pad_out[g] = serial_two_out[g];
					pad_oe[g] = serial_two_oe[g];
				end
				else
				begin
					pad_out[g] = st_ff.pin_data[g];
					pad_oe[g] = is_port[g] & st_ff.pin_direction[g];
				end
			end
			// edge and level detection
			assign rise = pin_in[g] & ~st_ff.pin_prev[g];
			assign fall = ~pin_in[g] & st_ff.pin_prev[g];
			assign cond[g] = st_ff.irq_sense_select[g]
				? (pin_in[g] == st_ff.irq_polarity[g])
				: (st_ff.irq_both_edges[g] ? (rise | fall)
					: (st_ff.irq_polarity[g] ? rise : fall));
		end
	endgenerate

	// ------------------------------------------------------------
	// pad and peripheral outputs
	// ------------------------------------------------------------
	// pins float while reset is held or just released
	assign pin_out = pad_out;
	assign pin_oe = (!aresetn || st_ff.in_reset) ? '0 : pad_oe;
	assign pin_pull_en = st_ff.pull_enable;
	assign pin_high_drive = st_ff.drive_strength;
	assign serial_zero_in = pin_in & is_s0;
	assign serial_one_in = pin_in & is_s1;
	assign serial_two_in = pin_in & is_s2;
	// timer capture routing, out-of-range index reads low
	assign timer_unit1_capture_a = sel_pin(pin_in, st_ff.timer_sel[7:0]);
	assign timer_unit1_capture_b = sel_pin(pin_in, st_ff.timer_sel[15:8]);
	assign timer_unit2_capture_a = sel_pin(pin_in, st_ff.timer_sel[23:16]);
	assign timer_unit2_capture_b = sel_pin(pin_in, st_ff.timer_sel[31:24]);
	assign masked = st_ff.pending & st_ff.irq_mask;
	assign irq = |masked;
	assign func_padded = {{(4*FW*8 - NPIN*FW){1'b0}}, st_ff.func};

	// pick a pin level by index; levels passed in so the assignment follows pin changes
	function automatic logic sel_pin(input logic [NPIN-1:0] lv, input logic [7:0] idx);
		sel_pin = (idx <= gpm_pkg::TSEL_MAX) ? lv[idx[4:0]] : 1'b0;
	endfunction

	// spread 8 packed 3-bit fields into a 4-bit stride word
	function automatic logic [31:0] spread(input logic [4*FW*8-1:0] f, input int unsigned base);
		logic [31:0] w;
		w = '0;
		for (int i = 0; i < 8; i++)
			w[i*4 +: FW] = f[(base + i)*FW +: FW];
		return w;
	endfunction

	// axi handshake outputs
	assign s_axi_awready = ~st_ff.aw_held;
	assign s_axi_wready = ~st_ff.w_held;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = ~st_ff.rvalid;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;

	// ------------------------------------------------------------
	// next state: bus slave, registers, pending flags
	// ------------------------------------------------------------
	always_comb
	begin
		logic [31:0] wm;
		logic [NPIN-1:0] wv;
		logic [NPIN-1:0] clr;
		logic do_wr;
		logic [6:0] ra;
		logic [31:0] rd;
		logic rok;
		nxt_st = st_ff;
		clr = '0;
		wm = '0;
		wv = '0;
		ra = s_axi_araddr;
		rd = '0;
		rok = 1'b1;
		nxt_st.in_reset = 1'b0;
		nxt_st.pin_prev = pin_in;
		// capture address and data in either order
		if (s_axi_awvalid && !st_ff.aw_held)
		begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_ff.w_held)
		begin
			nxt_st.w_held = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		do_wr = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
		for (int b = 0; b < 4; b++)
			wm[b*8 +: 8] = {8{st_ff.w_strb[b]}};
		wv = NPIN'((st_ff.w_data & wm) | (32'(st_ff.pin_data) & ~wm));
		if (do_wr)
		begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = gpm_pkg::RESP_OKAY;
			// bits above pin 25 are not stored, except in the timer select register
			case ({st_ff.aw_addr[6:2], 2'b00})
				gpm_pkg::OFF_PIN_DATA: nxt_st.pin_data = wv;
				gpm_pkg::OFF_PIN_DIRECTION: nxt_st.pin_direction = mrg(st_ff.pin_direction);
				gpm_pkg::OFF_PULL_ENABLE: nxt_st.pull_enable = mrg(st_ff.pull_enable);
				gpm_pkg::OFF_DRIVE_STRENGTH: nxt_st.drive_strength = mrg(st_ff.drive_strength);
				gpm_pkg::OFF_IRQ_SENSE_SELECT: nxt_st.irq_sense_select = mrg(st_ff.irq_sense_select);
				gpm_pkg::OFF_IRQ_BOTH_EDGES: nxt_st.irq_both_edges = mrg(st_ff.irq_both_edges);
				gpm_pkg::OFF_IRQ_POLARITY: nxt_st.irq_polarity = mrg(st_ff.irq_polarity);
				gpm_pkg::OFF_IRQ_MASK: nxt_st.irq_mask = mrg(st_ff.irq_mask);
				gpm_pkg::OFF_IRQ_CLEAR: clr = NPIN'(st_ff.w_data & wm);
				gpm_pkg::OFF_FUNCTION_SELECT_0: nxt_st.func = wfunc(0);
				gpm_pkg::OFF_FUNCTION_SELECT_1: nxt_st.func = wfunc(8);
				gpm_pkg::OFF_FUNCTION_SELECT_2: nxt_st.func = wfunc(16);
				gpm_pkg::OFF_FUNCTION_SELECT_3: nxt_st.func = wfunc(24);
				gpm_pkg::OFF_DATA_ATOMIC_SET:
					nxt_st.pin_data = st_ff.pin_data | (NPIN'(st_ff.w_data & wm) & is_port);
				gpm_pkg::OFF_DATA_ATOMIC_CLEAR:
					nxt_st.pin_data = st_ff.pin_data & ~(NPIN'(st_ff.w_data & wm) & is_port);
				gpm_pkg::OFF_TIMER_INPUT_SELECT:
					nxt_st.timer_sel = (st_ff.w_data & wm) | (st_ff.timer_sel & ~wm);
				gpm_pkg::OFF_IRQ_MASKED_STATUS: ; // read-only, write ignored
				7'h20: ; // hole reads zero, ignores writes
				default: nxt_st.bresp = gpm_pkg::RESP_SLVERR;
			endcase
		end
		if (st_ff.bvalid && s_axi_bready)
			nxt_st.bvalid = 1'b0;
		// pending: a new event wins over a clear in the same cycle
		nxt_st.pending = (st_ff.pending & ~clr) | cond;
		// read path, one-cycle answer
		if (s_axi_arvalid && !st_ff.rvalid)
		begin
			case ({ra[6:2], 2'b00})
				gpm_pkg::OFF_PIN_DATA: rd = 32'(pin_in);
				gpm_pkg::OFF_PIN_DIRECTION: rd = 32'(st_ff.pin_direction);
				gpm_pkg::OFF_PULL_ENABLE: rd = 32'(st_ff.pull_enable);
				gpm_pkg::OFF_DRIVE_STRENGTH: rd = 32'(st_ff.drive_strength);
				gpm_pkg::OFF_IRQ_SENSE_SELECT: rd = 32'(st_ff.irq_sense_select);
				gpm_pkg::OFF_IRQ_BOTH_EDGES: rd = 32'(st_ff.irq_both_edges);
				gpm_pkg::OFF_IRQ_POLARITY: rd = 32'(st_ff.irq_polarity);
				gpm_pkg::OFF_IRQ_MASK: rd = 32'(st_ff.irq_mask);
				gpm_pkg::OFF_IRQ_MASKED_STATUS: rd = 32'(masked);
				gpm_pkg::OFF_FUNCTION_SELECT_0: rd = spread(func_padded, 0);
				gpm_pkg::OFF_FUNCTION_SELECT_1: rd = spread(func_padded, 8);
				gpm_pkg::OFF_FUNCTION_SELECT_2: rd = spread(func_padded, 16);
				gpm_pkg::OFF_FUNCTION_SELECT_3: rd = spread(func_padded, 24);
				gpm_pkg::OFF_TIMER_INPUT_SELECT: rd = st_ff.timer_sel;
				gpm_pkg::OFF_IRQ_CLEAR, gpm_pkg::OFF_DATA_ATOMIC_SET,
				gpm_pkg::OFF_DATA_ATOMIC_CLEAR, 7'h20: rd = '0;
				default: rok = 1'b0;
			endcase
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd;
			nxt_st.rresp = rok ? gpm_pkg::RESP_OKAY : gpm_pkg::RESP_SLVERR;
		end
		else if (st_ff.rvalid && s_axi_rready)
			nxt_st.rvalid = 1'b0;
	end

	// merge written bytes into a per-pin register
	function automatic logic [NPIN-1:0] mrg(input logic [NPIN-1:0] old);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++)
			m[b*8 +: 8] = {8{st_ff.w_strb[b]}};
		return NPIN'((st_ff.w_data & m) | (32'(old) & ~m));
	endfunction

	// write up to eight function fields from base pin, reserved bits dropped
	function automatic logic [NPIN*FW-1:0] wfunc(input int unsigned base);
		logic [NPIN*FW-1:0] f;
		f = st_ff.func;
		for (int i = 0; i < 8; i++)
			if ((base + i) < NPIN && st_ff.w_strb[i/2])
				f[(base + i)*FW +: FW] = st_ff.w_data[i*4 +: FW];
		return f;
	endfunction

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff <= '0;
			st_ff.in_reset <= 1'b1;
			st_ff.pull_enable <= gpm_pkg::RST_PULL_ENABLE[NPIN-1:0];
			st_ff.func <= gpm_pkg::RST_FUNC[NPIN*FW-1:0];
		end
		else
			st_ff <= nxt_st;
	end
endmodule

// ### dv/gpio_port_with_pin_mux_tb.sv
// testbench for the pin port: register table, pin drive, mux, capture, interrupts
// assumes the pad model on the pins and an AXI4-Lite master in this module
module gpio_port_with_pin_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic w; logic [6:0] a; logic [31:0] d; logic [31:0] e;} gpm_row_t;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
	logic timer_unit1_capture_a, timer_unit1_capture_b, timer_unit2_capture_a, timer_unit2_capture_b;
	logic [6:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
	logic [25:0] pin_in, pin_out, pin_oe, pin_pull_en, pin_high_drive, ext_val, ext_en;
	logic [25:0] serial_zero_out, serial_zero_oe, serial_one_out, serial_one_oe;
	logic [25:0] serial_two_out, serial_two_oe, serial_zero_in, serial_one_in, serial_two_in;
	logic [2:0] codes [4] = '{gpm_pkg::FN_PORT, gpm_pkg::FN_SERIAL_ONE, gpm_pkg::FN_SERIAL_ZERO,
		gpm_pkg::FN_SERIAL_TWO};
	int bad_count, cmp_count;
	gpm_row_t rows [15] = '{'{1'h0, 7'h04, 32'h0, 32'h0}, '{1'h0, 7'h08, 32'h0, 32'h3ffffff},
		'{1'h0, 7'h0c, 32'h0, 32'h0}, '{1'h0, 7'h1c, 32'h0, 32'h0}, '{1'h0, 7'h30, 32'h0, 32'h110},
		'{1'h0, 7'h34, 32'h0, 32'h0}, '{1'h1, 7'h04, '1, 32'h3ffffff}, '{1'h1, 7'h08, 32'h0, 32'h0},
		'{1'h1, 7'h0c, '1, 32'h3ffffff}, '{1'h1, 7'h2c, '1, 32'h77777777},
		'{1'h1, 7'h34, '1, 32'h77777777}, '{1'h1, 7'h38, '1, 32'h77},
		'{1'h1, 7'h44, 32'h12345678, 32'h12345678}, '{1'h1, 7'h24, '1, 32'h0},
		'{1'h1, 7'h20, '1, 32'h0}};
	gpm_port gpm_port_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pin_pull_en,
		.pin_high_drive, .serial_zero_out, .serial_zero_oe, .serial_one_out, .serial_one_oe,
		.serial_two_out, .serial_two_oe, .serial_zero_in, .serial_one_in, .serial_two_in,
		.timer_unit1_capture_a, .timer_unit1_capture_b, .timer_unit2_capture_a,
		.timer_unit2_capture_b, .irq);
	gpm_pins_model gpm_pins_model_inst (.aclk, .pin_out, .pin_oe, .pin_pull_en, .ext_val,
		.ext_en, .pin_in);
	// clock, 40 ns period
	initial
	begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end
	// count and report one comparison
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one write; ready sampled mid-cycle, signals change after the edge
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			resp_q = s_axi_bresp;
			@(posedge aclk);
			if (aw_t)
				s_axi_awvalid <= 1'h0;
			if (w_t)
				s_axi_wvalid <= 1'h0;
		end
		while (!b_t);
		s_axi_bready <= 1'h0;
	endtask
	// one read, data and response kept in rd_q and resp_q
	task automatic rd(input logic [6:0] a);
		logic ar_t, r_t;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			rd_q = s_axi_rdata;
			resp_q = s_axi_rresp;
			@(posedge aclk);
			if (ar_t)
				s_axi_arvalid <= 1'h0;
		end
		while (!r_t);
		s_axi_rready <= 1'h0;
	endtask
	task automatic chk(input logic [6:0] a, input logic [31:0] e);
		rd(a);
		cmp(rd_q, e);
	endtask
	// reset held 12 cycles, pads checked released meanwhile
	task automatic reset_dut();
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (12) @(posedge aclk);
		cmp(32'(pin_oe), 32'h0);
		aresetn <= 1'h1;
	endtask
	// drive pin 25 from outside and let the detector see it
	task automatic pin25(input logic v);
		ext_val[25] <= v;
		repeat (4) @(posedge aclk);
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		end_of_test();
	end
	// main sequence: register rows, then pins, mux, capture, interrupts
	initial
	begin
		aresetn = 1'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{ext_val, ext_en, serial_zero_out, serial_zero_oe, serial_one_out} = '0;
		{serial_one_oe, serial_two_out, serial_two_oe} = '0;
		reset_dut();
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			chk(rows[i].a, rows[i].e);
		end
		cmp(32'(pin_pull_en), 32'h0);
		cmp(32'(pin_high_drive), 32'h3ffffff);
		rd(7'h48);
		cmp(32'(resp_q), 32'(gpm_pkg::RESP_SLVERR));
		wr(7'h48, '1);
		cmp(32'(resp_q), 32'(gpm_pkg::RESP_SLVERR));
		reset_dut();
		wr(7'h00, 32'h5);
		wr(7'h04, 32'hf);
		chk(7'h00, 32'h5);
		cmp(32'(pin_oe), 32'hf);
		wr(7'h3c, 32'h60a);
		wr(7'h40, 32'h5);
		wr(7'h30, 32'h0);
		wr(7'h04, 32'h60f);
		chk(7'h00, 32'ha);
		{serial_zero_oe, serial_one_oe, serial_two_oe} <= '1;
		foreach (codes[k])
		begin
			serial_zero_out <= {26{codes[k] == 3'h4}};
			serial_one_out <= {26{codes[k] == 3'h1}};
			serial_two_out <= {26{codes[k] == 3'h5}};
			wr(7'h2c, 32'(codes[k]));
			cmp(32'({pin_oe[0], pin_out[0]}), 32'({1'h1, codes[k] != 3'h0}));
			cmp(32'({serial_zero_in[0], serial_one_in[0], serial_two_in[0]}),
				32'({codes[k] == 3'h4, codes[k] == 3'h1, codes[k] == 3'h5}));
		end
		{ext_en[25], ext_val[25]} <= 2'h3;
		wr(7'h44, 32'h19030201);
		cmp(32'({timer_unit1_capture_a, timer_unit1_capture_b, timer_unit2_capture_a,
			timer_unit2_capture_b}), 32'hb);
		wr(7'h44, 32'h1a030201);
		cmp(32'({timer_unit1_capture_a, timer_unit1_capture_b, timer_unit2_capture_a,
			timer_unit2_capture_b}), 32'ha);
		wr(7'h18, 32'h2000000);
		wr(7'h1c, 32'h2000000);
		wr(7'h28, 32'h3ffffff);
		pin25(1'h0);
		chk(7'h24, 32'h0);
		pin25(1'h1);
		chk(7'h24, 32'h2000000);
		cmp(32'(irq), 32'h1);
		wr(7'h28, 32'h0);
		chk(7'h24, 32'h2000000);
		wr(7'h28, 32'h2000000);
		chk(7'h24, 32'h0);
		wr(7'h14, 32'h2000000);
		pin25(1'h0);
		chk(7'h24, 32'h2000000);
		wr(7'h18, 32'h0);
		wr(7'h10, 32'h2000000);
		wr(7'h28, 32'h2000000);
		chk(7'h24, 32'h2000000);
		wr(7'h1c, 32'h0);
		chk(7'h24, 32'h0);
		cmp(32'(irq), 32'h0);
		reset_dut();
		chk(7'h04, 32'h0);
		end_of_test();
	end
endmodule

// ### dv/gpm_pins_model.sv
// pad model for the pins: device drive, outside source, pull-down or floating
// assumes pulls pull down and an undriven unpulled pad wanders every cycle
module gpm_pins_model #(
	parameter int unsigned NPIN = 26
) (
	input wire logic aclk,
	input wire logic [NPIN-1:0] pin_out,
	input wire logic [NPIN-1:0] pin_oe,
	input wire logic [NPIN-1:0] pin_pull_en,
	input wire logic [NPIN-1:0] ext_val,
	input wire logic [NPIN-1:0] ext_en,
	output logic [NPIN-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NPIN-1:0] flt_ff = '0;
	// floating pads change every cycle so no stale level is seen
	always_ff @(posedge aclk)
		flt_ff <= ~flt_ff;
	// device drive wins, then the outside source, then the pull
	always_comb
		for (int i = 0; i < NPIN; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : !pin_pull_en[i] & flt_ff[i];
endmodule

// ### dv/gpm_port_checker.sv
// checker for the pin port: reset levels, read data and reserved fields
// assumes binding into gpm_port, one clock, synchronous active-low reset
module gpm_port_checker #(
	parameter int unsigned NPIN = 26
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [6:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [NPIN-1:0] pin_in,
	input wire logic [NPIN-1:0] pin_oe,
	input wire logic [NPIN-1:0] pin_pull_en,
	input wire logic [NPIN-1:0] pin_high_drive,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] ra;
	// address of a read taken at this edge, else an unused code
	assign ra = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : 7'h7f;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_oe_after_rst: assert property ($rose(aresetn) |-> pin_oe == '0)
		else $error("pin driven at reset release");
	a_pull_rst: assert property (!$past(aresetn) |-> &pin_pull_en)
		else $error("pull enable not all set after reset");
	a_drive_rst: assert property ($rose(aresetn) |-> pin_high_drive == '0)
		else $error("high drive set after reset");
	a_irq_rst: assert property (!$past(aresetn) |-> !irq)
		else $error("interrupt high after reset");
	a_pin_read: assert property (ra == 7'h00 |=> s_axi_rdata == 32'($past(pin_in)))
		else $error("data read differs from pin levels");
	a_hole_zero: assert property (ra == 7'h20 |=> s_axi_rdata == '0)
		else $error("unused offset reads nonzero");
	a_fsel_resv: assert property (ra inside {7'h2c, 7'h30, 7'h34} |=> !(|(s_axi_rdata & 32'h88888888)))
		else $error("reserved function bit reads one");
	a_fsel3_resv: assert property (ra == 7'h38 |=> s_axi_rdata[31:7] == '0 && !s_axi_rdata[3])
		else $error("last function register reserved bits set");
	a_mis_irq: assert property (ra == 7'h24 |=> (|s_axi_rdata) == $past(irq))
		else $error("interrupt output disagrees with masked status");
endmodule

bind gpm_port gpm_port_checker #(.NPIN(NPIN)) gpm_port_checker_inst (.aclk, .aresetn,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .pin_in, .pin_oe,
	.pin_pull_en, .pin_high_drive, .irq);
